// File: hw/raster_pixel_pipeline.sv
// raster pixel pipeline: fetch, unpack, colour tables, blink, cursor, dither, pwm
//
// Chosen here: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module raster_pixel_pipeline #(
  parameter int LUT_DEPTH = 256,
  parameter int MAX_H = raster_pkg::MAX_H,
  parameter int MAX_V = raster_pkg::MAX_V
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [31:0] reg_rdata,
  output logic mem_req,
  output logic [31:0] mem_addr,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic frame_start,
  input wire logic pix_ready,
  output logic pix_valid,
  output logic [17:0] pix_data,
  output logic pwm_out
);
  import raster_pkg::*;

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  logic [31:0] ctrl_q, start_q, pitch_q, size_q, blink_rate_q, blink_mask_q;
  logic [23:0] bg_q, cur_colour_q;
  logic [31:0] cur_pos_q;
  logic [7:0] pwm_duty_q;
  logic [8:0] lut_addr_q;
  logic [31:0] rdata_q;
  logic [23:0] lut0 [LUT_DEPTH];
  logic [23:0] lut1 [LUT_DEPTH];

  wire run_en = ctrl_q[0];
  wire [2:0] mode = ctrl_q[3:1];
  wire lut_sel = ctrl_q[4];
  wire region_sel = ctrl_q[5];
  wire [1:0] dither_mode = ctrl_q[7:6];
  wire [2:0] blink_op = ctrl_q[10:8];
  wire blink_en = ctrl_q[11];
  wire [10:0] hres = size_q[10:0];
  wire [10:0] vres = size_q[26:16];
  wire [7:0] blink_rate = blink_rate_q[7:0];
  wire [7:0] blink_mask = blink_mask_q[7:0];
  wire [7:0] blink_key = blink_mask_q[15:8];
  wire [10:0] cur_x = cur_pos_q[10:0];
  wire [10:0] cur_y = cur_pos_q[26:16];
  wire wr_lut_data = reg_we && reg_addr == REG_LUT_DATA;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_q <= CTRL_RESET;
      start_q <= 32'h0;
      pitch_q <= 32'h0;
      size_q <= 32'h0;
      blink_rate_q <= 32'h0;
      blink_mask_q <= 32'h0;
      bg_q <= 24'h0;
      cur_pos_q <= 32'h0;
      cur_colour_q <= 24'h0;
      pwm_duty_q <= 8'h0;
      lut_addr_q <= 9'h0;
    end else if (reg_we) begin
      case (reg_addr)
        REG_CTRL: ctrl_q <= reg_wdata;
        REG_START: start_q <= {reg_wdata[31:2], 2'b00};
        REG_PITCH: pitch_q <= {reg_wdata[31:2], 2'b00};
        REG_SIZE: size_q <= reg_wdata;
        REG_BLINK_PERIOD_CONTROL: blink_rate_q <= reg_wdata;
        REG_BLINK_MASK: blink_mask_q <= reg_wdata;
        REG_BG: bg_q <= reg_wdata[23:0];
        REG_CURSOR_POS: cur_pos_q <= reg_wdata;
        REG_CURSOR_COLOUR: cur_colour_q <= reg_wdata[23:0];
        REG_PWM: pwm_duty_q <= reg_wdata[7:0];
        REG_LUT_ADDR: lut_addr_q <= reg_wdata[8:0];
        REG_LUT_DATA: lut_addr_q <= {lut_addr_q[8], lut_addr_q[7:0] + 8'h01};
        default: ;
      endcase
    end
  end

  // table writes carry no reset: contents are software's to load
  always_ff @(posedge clock) begin
    if (wr_lut_data && !lut_addr_q[8]) begin
      lut0[lut_addr_q[7:0]] <= reg_wdata[23:0];
    end
    if (wr_lut_data && lut_addr_q[8]) begin
      lut1[lut_addr_q[7:0]] <= reg_wdata[23:0];
    end
  end

  // ----------------------------------------------------------------------
  // frame counter and blink phase
  // ----------------------------------------------------------------------
  logic [7:0] frame_q, blink_cnt_q;
  logic blink_off_q;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      frame_q <= 8'h0;
      blink_cnt_q <= 8'h0;
      blink_off_q <= 1'b0;
    end else if (frame_start) begin
      frame_q <= frame_q + 8'h01;
      if (blink_cnt_q >= blink_rate) begin
        blink_cnt_q <= 8'h0;
        blink_off_q <= !blink_off_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // word fetch and bit accumulator
  // ----------------------------------------------------------------------
  fetch_state_t state_q;
  logic [31:0] line_addr_q, word_addr_q;
  logic [63:0] acc_q;
  logic [6:0] cnt_q;
  logic [10:0] x_q, y_q;
  logic req_q;
  logic pix_valid_q;
  logic [17:0] pix_data_q;

  logic [6:0] pix_bits;
  always_comb begin
    case (mode)
      MODE_4: pix_bits = 7'd4;
      MODE_8: pix_bits = 7'd8;
      MODE_16: pix_bits = 7'd16;
      MODE_24P: pix_bits = 7'd24;
      default: pix_bits = 7'd32;
    endcase
  end

  // 4 bpp nibbles are swapped on load so that bits leave lsb first in screen order
  logic [31:0] word_in;
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb++) begin : g_nib
      assign word_in[8*gb +: 8] = (mode == MODE_4) ?
        {mem_rdata[8*gb +: 4], mem_rdata[8*gb+4 +: 4]} : mem_rdata[8*gb +: 8];
    end
  endgenerate

  wire have_pix = state_q == ST_RUN && cnt_q >= pix_bits;
  wire advance = have_pix && (!pix_valid_q || pix_ready);
  wire line_end = advance && x_q == hres - 11'd1;
  wire frame_end = line_end && y_q == vres - 11'd1;
  wire [63:0] acc_used = advance ? (acc_q >> pix_bits) : acc_q;
  wire [6:0] cnt_used = advance ? cnt_q - pix_bits : cnt_q;
  wire load = req_q && mem_ack;
  wire [63:0] acc_next = load ? (acc_used | ({32'h0, word_in} << cnt_used)) : acc_used;
  wire [6:0] cnt_next = load ? cnt_used + 7'd32 : cnt_used;
  wire [31:0] frame_base = region_sel ? VIDEO_REGION_BASE + start_q : start_q;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      line_addr_q <= 32'h0;
      word_addr_q <= 32'h0;
      acc_q <= 64'h0;
      cnt_q <= 7'h0;
      x_q <= 11'h0;
      y_q <= 11'h0;
      req_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (frame_start && run_en && hres != 11'h0 && vres != 11'h0) begin
            line_addr_q <= frame_base;
            word_addr_q <= frame_base;
            acc_q <= 64'h0;
            cnt_q <= 7'h0;
            x_q <= 11'h0;
            y_q <= 11'h0;
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          acc_q <= acc_next;
          cnt_q <= cnt_next;
          if (load) begin
            req_q <= 1'b0;
            word_addr_q <= word_addr_q + 32'h4;
          end else if (!req_q && cnt_used <= 7'd32 && !line_end) begin
            req_q <= 1'b1;
          end
          if (advance) begin
            x_q <= line_end ? 11'h0 : x_q + 11'h1;
          end
          if (line_end) begin
            y_q <= y_q + 11'h1;
            state_q <= frame_end ? ST_IDLE : ST_NEXT;
          end
        end
        ST_NEXT: begin
          // a word still in flight is taken and thrown away before the jump
          if (load) begin
            req_q <= 1'b0;
          end
          if (!req_q || load) begin
            acc_q <= 64'h0;
            cnt_q <= 7'h0;
            line_addr_q <= line_addr_q + pitch_q;
            word_addr_q <= line_addr_q + pitch_q;
            state_q <= ST_RUN;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
      if (frame_end) begin
        req_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // colour formation and blink
  // ----------------------------------------------------------------------
  wire [31:0] raw = acc_q[31:0];
  wire low_mode = mode == MODE_4 || mode == MODE_8;
  wire [7:0] idx = (mode == MODE_4) ? {4'h0, raw[3:0]} : raw[7:0];
  wire blinking = blink_en && blink_off_q && (idx & blink_mask) != 8'h0;

  logic [7:0] idx_t;
  always_comb begin
    idx_t = idx;
    if (blinking && low_mode) begin
      case (blink_op)
        BLINK_AND: idx_t = idx & blink_key;
        BLINK_OR: idx_t = idx | blink_key;
        BLINK_XOR: idx_t = idx ^ blink_key;
        default: idx_t = idx;
      endcase
    end
  end

  wire [23:0] lut_out = lut_sel ? lut1[idx_t] : lut0[idx_t];
  wire [23:0] rgb565 = {raw[15:11], raw[15:13], raw[10:5], raw[10:9], raw[4:0], raw[4:2]};
  wire [23:0] base_rgb = low_mode ? lut_out : (mode == MODE_16) ? rgb565 : raw[23:0];

  logic [23:0] blink_rgb;
  always_comb begin
    blink_rgb = base_rgb;
    if (blinking) begin
      case (blink_op)
        BLINK_BG: blink_rgb = bg_q;
        BLINK_DIM: blink_rgb = {1'b0, base_rgb[23:17], 1'b0, base_rgb[15:9],
          1'b0, base_rgb[7:1]};
        BLINK_BRIGHT: blink_rgb = {1'b1, base_rgb[23:17], 1'b1, base_rgb[15:9],
          1'b1, base_rgb[7:1]};
        BLINK_REV: blink_rgb = ~base_rgb;
        default: blink_rgb = base_rgb;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // cursor and dither
  // ----------------------------------------------------------------------
  // clipping falls out of the scan: only on-screen positions are ever compared
  wire [11:0] cur_x_end = {1'b0, cur_x} + 12'(CURSOR_SIZE);
  wire [11:0] cur_y_end = {1'b0, cur_y} + 12'(CURSOR_SIZE);
  wire cur_hit = cur_pos_q[31] && x_q >= cur_x && {1'b0, x_q} < cur_x_end &&
    y_q >= cur_y && {1'b0, y_q} < cur_y_end;
  wire [23:0] shown = cur_hit ? cur_colour_q : blink_rgb;

  // threshold walks with frame and position; levels 0 and 7 never flicker
  wire [12:0] dsum = {5'h0, frame_q} + {2'b0, x_q} + {1'b0, y_q, 1'b0};
  wire [2:0] thr = 3'(dsum % 13'd7);
  wire gray_on = shown[15:13] > thr;
  wire r_on = shown[23:21] > thr;
  wire g_on = shown[15:13] > thr;
  wire b_on = shown[7:5] > thr;

  logic [17:0] pins_d;
  always_comb begin
    case (dither_mode)
      DITHER_GRAY: pins_d = {18{gray_on}};
      DITHER_COLOUR: pins_d = {{6{r_on}}, {6{g_on}}, {6{b_on}}};
      default: pins_d = {shown[23:18], shown[15:10], shown[7:2]};
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pix_valid_q <= 1'b0;
      pix_data_q <= 18'h0;
    end else if (advance) begin
      pix_valid_q <= 1'b1;
      pix_data_q <= pins_d;
    end else if (pix_ready) begin
      pix_valid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // brightness pwm and read port
  // ----------------------------------------------------------------------
  logic [7:0] pwm_cnt_q;
  logic pwm_q;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pwm_cnt_q <= 8'h0;
      pwm_q <= 1'b0;
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 8'h01;
      pwm_q <= pwm_cnt_q < pwm_duty_q;
    end
  end

  logic [31:0] rd_d;
  always_comb begin
    case (reg_addr)
      REG_CTRL: rd_d = ctrl_q;
      REG_START: rd_d = start_q;
      REG_PITCH: rd_d = pitch_q;
      REG_SIZE: rd_d = size_q;
      REG_BLINK_PERIOD_CONTROL: rd_d = blink_rate_q;
      REG_BLINK_MASK: rd_d = blink_mask_q;
      REG_BG: rd_d = {8'h0, bg_q};
      REG_CURSOR_POS: rd_d = cur_pos_q;
      REG_CURSOR_COLOUR: rd_d = {8'h0, cur_colour_q};
      REG_PWM: rd_d = {24'h0, pwm_duty_q};
      REG_LUT_ADDR: rd_d = {23'h0, lut_addr_q};
      REG_STATUS: rd_d = {blink_off_q, state_q != ST_IDLE, 3'h0, y_q, 8'h0, frame_q};
      default: rd_d = 32'h0;
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= reg_re ? rd_d : 32'h0;
    end
  end

  assign reg_rdata = rdata_q;
  assign mem_req = req_q;
  assign mem_addr = word_addr_q;
  assign pix_valid = pix_valid_q;
  assign pix_data = pix_data_q;
  assign pwm_out = pwm_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  blink_toggle_a: assert property (@(posedge clock) disable iff (reset)
    frame_start && blink_cnt_q >= blink_rate |=> blink_off_q != $past(blink_off_q))
    else $error("blink phase did not toggle at rate");
  blink_hold_a: assert property (@(posedge clock) disable iff (reset)
    frame_start && blink_cnt_q < blink_rate |=> blink_off_q == $past(blink_off_q))
    else $error("blink phase toggled early");
  frame_origin_a: assert property (@(posedge clock) disable iff (reset)
    state_q == ST_IDLE && frame_start && run_en && hres != 11'h0 && vres != 11'h0
    |=> mem_addr == $past(frame_base) && x_q == 11'h0 && y_q == 11'h0)
    else $error("frame does not start at screen start");
  word_step_a: assert property (@(posedge clock) disable iff (reset)
    state_q == ST_RUN && load |=> mem_addr == $past(mem_addr) + 32'h4)
    else $error("fetch address not ascending by one word");
  word_align_a: assert property (@(posedge clock) disable iff (reset)
    mem_req |-> mem_addr[1:0] == 2'b00)
    else $error("fetch address not word aligned");
  pitch_jump_a: assert property (@(posedge clock) disable iff (reset)
    state_q == ST_NEXT && (!req_q || load) |=> mem_addr == $past(line_addr_q) + pitch_q)
    else $error("next line does not follow pitch");
  req_hold_a: assert property (@(posedge clock) disable iff (reset)
    mem_req && !mem_ack && !frame_end |=> mem_req && $stable(mem_addr))
    else $error("fetch request dropped before acknowledge");
  pix_hold_a: assert property (@(posedge clock) disable iff (reset)
    pix_valid && !pix_ready |=> pix_valid && $stable(pix_data))
    else $error("pixel changed while not taken");
  gray_levels_a: assert property (@(posedge clock) disable iff (reset)
    advance && dither_mode == DITHER_GRAY && shown[15:13] == 3'h7
    |=> pix_data == 18'h3FFFF)
    else $error("full gray level not fully on");
  nibble_order_a: assert property (@(posedge clock) disable iff (reset)
    state_q == ST_RUN && mode == MODE_4 && load && cnt_used == 7'h0
    |=> acc_q[3:0] == $past(mem_rdata[7:4]))
    else $error("4 bpp leftmost pixel not upper nibble");
  pwm_duty_a: assert property (@(posedge clock) disable iff (reset)
    pwm_duty_q == 8'h0 && $past(pwm_duty_q) == 8'h0 |-> !pwm_out)
    else $error("pwm high at zero duty");
endmodule
`default_nettype wire

// File: hw/raster_pkg.sv
// constants and types shared by the raster pixel pipeline
// ----------------------------------------------------------------------
// Notes on behaviour
// - blinking pixels toggle at the rate held in blink_period_control
// - in 4/8 bpp a bit-plane mask on the table index marks blinking values
// - in 16/24 bpp blinking transforms the pixel value itself, no table
// - blink offers and/or/xor index translation, background, dim, bright, reverse
// - two colour tables, 256 entries of 24-bit colour each
// - monochrome dithering gives eight gray levels including full on and off
// - colour dithering gives up to 512 colours on passive panels
// - dither on/off depends on frame count, screen position and pixel value
// - gray level comes from three bits of the pixel
// - colour comes from three bits each of red, green and blue
// - line pitch in memory may exceed the visible line, allowing panning
// - a line may start on any 32-bit word boundary
// - the upper-left screen corner address comes from the screen start register
// - words are fetched ascending along a line, lines top to bottom
// - in 4 bpp the upper nibble of each byte is the leftmost pixel
// - in 8 bpp pixel 0 is bits 7..0, pixel 3 is bits 31..24
// - the first pixel of a frame is pixel 0 of the first word
// - screens up to 1280x1024 at 4, 8, 16, 24 packed or 32 bpp
// - a pwm output gives a filterable brightness level
// - a hardware cursor is overlaid and clipped at the bottom and right edges
// - colour is 24 bits inside, 18 bits reach the pins
// - the frame buffer may sit in main memory or a dedicated video region
// ----------------------------------------------------------------------
package raster_pkg;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_START = 8'h04;
  localparam logic [7:0] REG_PITCH = 8'h08;
  localparam logic [7:0] REG_SIZE = 8'h0C;
  localparam logic [7:0] REG_BLINK_PERIOD_CONTROL = 8'h10;
  localparam logic [7:0] REG_BLINK_MASK = 8'h14;
  localparam logic [7:0] REG_BG = 8'h18;
  localparam logic [7:0] REG_CURSOR_POS = 8'h1C;
  localparam logic [7:0] REG_CURSOR_COLOUR = 8'h20;
  localparam logic [7:0] REG_PWM = 8'h24;
  localparam logic [7:0] REG_LUT_ADDR = 8'h28;
  localparam logic [7:0] REG_LUT_DATA = 8'h2C;
  localparam logic [7:0] REG_STATUS = 8'h30;
  localparam logic [2:0] MODE_4 = 3'h0;
  localparam logic [2:0] MODE_8 = 3'h1;
  localparam logic [2:0] MODE_16 = 3'h2;
  localparam logic [2:0] MODE_24P = 3'h3;
  localparam logic [2:0] MODE_32 = 3'h4;
  localparam logic [2:0] BLINK_AND = 3'h0;
  localparam logic [2:0] BLINK_OR = 3'h1;
  localparam logic [2:0] BLINK_XOR = 3'h2;
  localparam logic [2:0] BLINK_BG = 3'h3;
  localparam logic [2:0] BLINK_DIM = 3'h4;
  localparam logic [2:0] BLINK_BRIGHT = 3'h5;
  localparam logic [2:0] BLINK_REV = 3'h6;
  localparam logic [1:0] DITHER_OFF = 2'h0;
  localparam logic [1:0] DITHER_GRAY = 2'h1;
  localparam logic [1:0] DITHER_COLOUR = 2'h2;
  localparam int CURSOR_SIZE = 16;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] VIDEO_REGION_BASE = 32'h0800_0000;
  localparam int MAX_H = 1280;
  localparam int MAX_V = 1024;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_NEXT} fetch_state_t;
endpackage

// File: sim/panel_model.sv
// display panel model: takes pixels, promptly or with stalls
`timescale 1ns/1ns
`default_nettype none
module panel_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic pix_valid,
  input wire logic [17:0] pix_data,
  input wire logic slow,
  output logic pix_ready,
  output logic took,
  output logic [17:0] took_data
);
  logic [1:0] stall_q;
  // ----------------------------------------------------------------------
  // ready pattern
  // ----------------------------------------------------------------------
  // slow mode accepts one cycle in four, so the pipeline has to hold its pixel
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stall_q <= 2'h0;
      pix_ready <= 1'b0;
    end else begin
      stall_q <= stall_q + 2'h1;
      pix_ready <= slow ? (stall_q == 2'h3) : 1'b1;
    end
  end
  // ----------------------------------------------------------------------
  // capture
  // ----------------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      took <= 1'b0;
      took_data <= 18'h0;
    end else begin
      took <= pix_valid && pix_ready;
      took_data <= pix_data;
    end
  end
endmodule
`default_nettype wire

// File: sim/raster_pixel_pipeline_tb.sv
// testbench for the raster pixel pipeline
`timescale 1ns/1ns
`default_nettype none
module raster_pixel_pipeline_tb;
  import raster_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [31:0] reg_rdata;
  logic mem_req;
  logic [31:0] mem_addr;
  logic mem_ack = 1'b0;
  logic [31:0] mem_rdata = 32'h0;
  logic frame_start = 1'b0;
  logic pix_ready, pix_valid, pwm_out, slow, took, grab;
  logic [17:0] pix_data, took_data;
  logic [31:0] first_addr, rd;
  logic [17:0] exp_q[$];
  int err_total = 0;
  int tests_run = 0;
  int highs;
  // knobs for the later frames: upper control bits, cursor, blink background and planes
  logic [5:0] xc = 6'h0;
  logic [31:0] cpos = 32'h0;
  logic [23:0] ccol = 24'h0;
  logic [23:0] bgc = 24'h0;
  logic [7:0] bmask = 8'h0;

  always #25 clock = ~clock;

  raster_pixel_pipeline raster_pixel_pipeline_i (.clock(clock), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .frame_start(frame_start), .pix_ready(pix_ready),
    .pix_valid(pix_valid), .pix_data(pix_data), .pwm_out(pwm_out));
  panel_model panel_model_i (.clock(clock), .reset(reset), .pix_valid(pix_valid),
    .pix_data(pix_data), .slow(slow), .pix_ready(pix_ready), .took(took),
    .took_data(took_data));

  // ----------------------------------------------------------------------
  // memory model: byte at address a holds a[7:0]
  // ----------------------------------------------------------------------
  // between acks the data bus flips so stale words cannot pass for fresh ones
  always @(posedge clock) begin
    if (mem_req && !mem_ack) begin
      mem_ack <= 1'b1;
      mem_rdata <= {mem_addr[7:0] + 8'h3, mem_addr[7:0] + 8'h2, mem_addr[7:0] + 8'h1,
        mem_addr[7:0]};
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
    if (frame_start) begin
      grab <= 1'b1;
    end else if (mem_req && mem_ack && grab) begin
      first_addr <= mem_addr;
      grab <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [23:0] lut_val(input logic t, input logic [7:0] i);
    return t ? {~i, i, 8'h3C} : {i, 8'hC3, ~i};
  endfunction

  function automatic logic [17:0] px(input logic [23:0] c);
    return {c[23:18], c[15:10], c[7:2]};
  endfunction

  always @(negedge clock) begin
    if (took) begin
      if (exp_q.size() == 0) begin
        check({14'h0, took_data}, 32'hFFFF_FFFF);
      end else begin
        check({14'h0, took_data}, {14'h0, exp_q.pop_front()});
      end
    end
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clock);
    reg_we <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clock);
    reg_re <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic load_lut(input logic t);
    wr(REG_LUT_ADDR, {23'h0, t, 8'h00});
    for (int i = 0; i < 256; i++) begin
      wr(REG_LUT_DATA, {8'h0, lut_val(t, i[7:0])});
    end
  endtask

  task automatic run_frame(input logic [2:0] mode, input logic tsel, input logic region,
    input logic [31:0] start, input logic [31:0] pitch, input int h, input int v,
    input logic slw);
    logic [31:0] a;
    logic [7:0] b;
    int n;
    logic [31:0] st;
    logic [7:0] f;
    int t;
    logic [23:0] c;
    logic [17:0] p;
    rd_reg(REG_STATUS, st);
    f = st[7:0] + 8'h01;
    for (int y = 0; y < v; y++) begin
      for (int x = 0; x < h; x++) begin
        if (mode == MODE_4) begin
          a = start + y * pitch + x / 2;
          b = (x % 2) ? {4'h0, a[3:0]} : {4'h0, a[7:4]};
          c = lut_val(tsel, b);
        end else if (mode == MODE_8) begin
          a = start + y * pitch + x;
          b = a[7:0];
          c = lut_val(tsel, b);
        end else begin
          a = start + y * pitch + ((mode == MODE_24P) ? 3 : 4) * x;
          b = a[7:0];
          c = {a[7:0] + 8'h2, a[7:0] + 8'h1, a[7:0]};
        end
        // rate stays 0, so the phase flips at every frame start
        if (xc[5] && !st[31] && (b & bmask) != 8'h0) begin
          c = bgc;
        end
        if (cpos[31] && x >= cpos[10:0] && x < cpos[10:0] + CURSOR_SIZE &&
          y >= cpos[26:16] && y < cpos[26:16] + CURSOR_SIZE) begin
          c = ccol;
        end
        t = (f + x + 2 * y) % 7;
        case (xc[1:0])
          DITHER_GRAY: p = {18{c[15:13] > t}};
          DITHER_COLOUR: p = {{6{c[23:21] > t}}, {6{c[15:13] > t}}, {6{c[7:5] > t}}};
          default: p = px(c);
        endcase
        exp_q.push_back(p);
      end
    end
    slow <= slw;
    wr(REG_CTRL, {20'h0, xc, region, tsel, mode, 1'b1});
    wr(REG_START, start);
    wr(REG_PITCH, pitch);
    wr(REG_SIZE, {5'h0, v[10:0], 5'h0, h[10:0]});
    wr(REG_BLINK_MASK, {24'h0, bmask});
    wr(REG_BG, {8'h0, bgc});
    wr(REG_CURSOR_POS, cpos);
    wr(REG_CURSOR_COLOUR, {8'h0, ccol});
    @(posedge clock);
    frame_start <= 1'b1;
    @(posedge clock);
    frame_start <= 1'b0;
    n = 0;
    while (exp_q.size() != 0 && n < 4000) begin
      @(posedge clock);
      n++;
    end
    repeat (20) @(posedge clock);
    check(exp_q.size(), 0);
    check(first_addr, (region ? VIDEO_REGION_BASE : 32'h0) + start);
    exp_q.delete();
    $display("test frame mode %0d done", mode);
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    #2_000_000;
    err_total++;
    final_report();
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial begin
    slow = 1'b0;
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    rd_reg(REG_CTRL, rd);
    check(rd, CTRL_RESET);
    wr(REG_START, 32'h0000_0123);
    rd_reg(REG_START, rd);
    check(rd, 32'h0000_0120);
    @(posedge clock);
    #1;
    check(reg_rdata, 32'h0);
    rd_reg(8'hFC, rd);
    check(rd, 32'h0);
    $display("test registers done");
    load_lut(1'b0);
    load_lut(1'b1);
    $display("test tables loaded");
    run_frame(MODE_8, 1'b0, 1'b0, 32'h0000_0100, 32'h10, 8, 2, 1'b0);
    run_frame(MODE_4, 1'b1, 1'b0, 32'h0000_0044, 32'h8, 8, 2, 1'b1);
    run_frame(MODE_32, 1'b0, 1'b1, 32'h0000_0080, 32'h20, 2, 2, 1'b1);
    // cursor runs past the right edge of a 4 pixel line and must clip
    cpos = {1'b1, 4'h0, 11'd1, 5'h0, 11'd2};
    ccol = 24'hF0_0F_A5;
    run_frame(MODE_24P, 1'b0, 1'b0, 32'h0000_0200, 32'h10, 4, 2, 1'b0);
    cpos = 32'h0;
    xc = {1'b1, BLINK_BG, DITHER_GRAY};
    bmask = 8'h04;
    bgc = 24'h00_E0_00;
    run_frame(MODE_32, 1'b0, 1'b0, 32'h0000_0300, 32'h20, 2, 2, 1'b1);
    xc = {4'h0, DITHER_COLOUR};
    run_frame(MODE_8, 1'b0, 1'b0, 32'h0000_0140, 32'h10, 8, 2, 1'b0);
    wr(REG_PWM, 32'h0000_0040);
    repeat (300) @(posedge clock);
    highs = 0;
    for (int i = 0; i < 256; i++) begin
      @(negedge clock);
      highs += pwm_out ? 1 : 0;
    end
    check(highs, 64);
    $display("test pwm done");
    final_report();
  end
endmodule
`default_nettype wire
